// *** verilog/dmx_pkg.sv ***
`default_nettype none

package dmx_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int INSTR_W = 16;

   // ----------------------------------------------------------------
   // Opcode fields
   // ----------------------------------------------------------------
   localparam logic [3:0] OPC_MOVE_SRC = 4'hC;
   localparam logic [3:0] OPC_MOVE_DST = 4'hF;
   localparam logic [7:0] OPC_BANK_LIT = 8'h01;
   localparam logic [7:0] OPC_ACC_LIT = 8'h0E;
   localparam logic [6:0] OPC_ACC_STORE = 7'h37;
   localparam int ACCESS_BIT_POS = 8;

   // ----------------------------------------------------------------
   // Data space map
   // ----------------------------------------------------------------
   localparam logic [11:0] ACC_ADDR = 12'hFF0;
   localparam logic [11:0] PC_LOW_ADDR = 12'hFFB;
   localparam logic [11:0] STACK_UPPER_ADDR = 12'hFFE;
   localparam logic [11:0] STACK_HIGH_ADDR = 12'hFFD;
   localparam logic [11:0] STACK_LOW_ADDR = 12'hFFC;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [7:0] BANK_MASK = 8'h0F;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] BANK_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Instruction cycle phases
   // ----------------------------------------------------------------
   localparam logic [1:0] PHASE_Q1 = 2'h0;
   localparam logic [1:0] PHASE_Q2 = 2'h1;
   localparam logic [1:0] PHASE_Q3 = 2'h2;
   localparam logic [1:0] PHASE_Q4 = 2'h3;

   // Operation being executed
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_MOVE = 3'b001,
      OP_BANK = 3'b010,
      OP_ACCLIT = 3'b011,
      OP_STORE = 3'b100
   } dmx_op_t;

   // Instruction cycle within a move
   typedef enum logic {
      ST_FIRST = 1'b0,
      ST_SECOND = 1'b1
   } dmx_state_t;

endpackage

`default_nettype wire

// *** verilog/dmx_file_addr.sv ***
`timescale 1ns/10ps
`default_nettype none

module dmx_file_addr
   import dmx_pkg::*;
(
   // Instruction fields
   input wire logic [7:0] fileAddr,
   input wire logic accessBit,
   // Core state
   input wire logic [7:0] bankSelect,
   input wire logic extEnable,
   input wire logic [11:0] indexBase,
   // Result
   output logic [11:0] physAddr,
   output logic indexed
);

   // ----------------------------------------------------------------
   // Address forming
   // ----------------------------------------------------------------
   logic [11:0] bankedAddr;
   logic [11:0] accessAddr;
   logic [11:0] indexAddr;

   assign bankedAddr = {bankSelect[3:0], fileAddr};
   assign accessAddr = (fileAddr < ACCESS_SPLIT) ? {ACCESS_LO_BANK, fileAddr}
                                                 : {ACCESS_HI_BANK, fileAddr};
   assign indexAddr = indexBase + {4'h0, fileAddr};
   assign indexed = extEnable && !accessBit && (fileAddr <= INDEX_LIMIT);

   assign physAddr = accessBit ? bankedAddr : (indexed ? indexAddr : accessAddr);

endmodule // dmx_file_addr

`default_nettype wire

// *** verilog/dmx_move_exec.sv ***
`timescale 1ns/10ps
`default_nettype none

module dmx_move_exec
   import dmx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Instruction stream
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   output logic instrTaken,
   // Addressing mode
   input wire logic extEnable,
   input wire logic [11:0] indexBase,
   // Data memory read
   output logic memRdEn,
   output logic [11:0] memRdAddr,
   input wire logic [7:0] memRdData,
   // Data memory write
   output logic memWrEn,
   output logic [11:0] memWrAddr,
   output logic [7:0] memWrData,
   // Core state and status
   output logic [7:0] accumulator,
   output logic [7:0] bankSelect,
   output logic opDone,
   output logic badDest
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0] phase;
   dmx_op_t op;
   dmx_op_t next_op;
   dmx_state_t state;
   dmx_state_t next_state;
   logic [7:0] literal;
   logic [7:0] fileAddr;
   logic accessBit;
   logic [11:0] dstAddr;
   logic [7:0] moveData;
   logic wrAccDue;
   logic [11:0] storeAddr;
   logic storeIndexed;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic inQ1;
   logic inQ2;
   logic inQ3;
   logic inQ4;
   logic isMove;
   logic isSecond;
   logic isBankLit;
   logic isAccLit;
   logic isStore;
   logic takeFirst;
   logic takeSecond;
   logic [11:0] wrAddr;
   logic wrDue;
   logic wrIsAcc;
   logic dstProtected;
   logic [7:0] readValue;

   // Phase strobes
   assign inQ1 = (phase == PHASE_Q1);
   assign inQ2 = (phase == PHASE_Q2);
   assign inQ3 = (phase == PHASE_Q3);
   assign inQ4 = (phase == PHASE_Q4);

   // Opcode matches
   assign isMove = (instrWord[15:12] == OPC_MOVE_SRC);
   assign isSecond = (instrWord[15:12] == OPC_MOVE_DST);
   assign isBankLit = (instrWord[15:8] == OPC_BANK_LIT);
   assign isAccLit = (instrWord[15:8] == OPC_ACC_LIT);
   assign isStore = (instrWord[15:9] == OPC_ACC_STORE);

   // Word taken in decode phase
   assign takeFirst = inQ1 && instrValid && (state == ST_FIRST);
   assign takeSecond = inQ1 && instrValid && (state == ST_SECOND) && (op == OP_MOVE) && isSecond;
   assign instrTaken = inQ1 && instrValid;

   assign dstProtected = (dstAddr == PC_LOW_ADDR) || (dstAddr == STACK_UPPER_ADDR) ||
                         (dstAddr == STACK_HIGH_ADDR) || (dstAddr == STACK_LOW_ADDR);

   assign readValue = (memRdAddr == ACC_ADDR) ? accumulator : memRdData;
   assign wrAddr = (op == OP_MOVE) ? dstAddr : storeAddr;
   assign wrIsAcc = (wrAddr == ACC_ADDR);
   assign wrDue = ((op == OP_STORE) && (state == ST_FIRST)) ||
                  ((op == OP_MOVE) && (state == ST_SECOND) && !dstProtected);

   // Completion strobe in last phase
   assign opDone = inQ4 && (op != OP_NONE) && ((op != OP_MOVE) || (state == ST_SECOND));

   // ----------------------------------------------------------------
   // Store address forming
   // ----------------------------------------------------------------
   dmx_file_addr u_file_addr (
      .fileAddr(fileAddr),
      .accessBit(accessBit),
      .bankSelect(bankSelect),
      .extEnable(extEnable),
      .indexBase(indexBase),
      .physAddr(storeAddr),
      .indexed(storeIndexed)
   );

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   // Operation chosen at decode
   always_comb
   begin
      next_op = op;
      if (takeFirst)
      begin
         if (isMove)
            next_op = OP_MOVE;
         else if (isBankLit)
            next_op = OP_BANK;
         else if (isAccLit)
            next_op = OP_ACCLIT;
         else if (isStore)
            next_op = OP_STORE;
         else
            next_op = OP_NONE;
      end
      else if (inQ1 && (state == ST_FIRST))
         next_op = OP_NONE;
      else if (inQ1 && (state == ST_SECOND) && !takeSecond)
         next_op = OP_NONE;
   end

   always_comb
   begin
      next_state = state;
      if (inQ4 && (state == ST_FIRST) && (op == OP_MOVE))
         next_state = ST_SECOND;
      else if (inQ4)
         next_state = ST_FIRST;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phase <= PHASE_Q1;
      else
         phase <= phase + 2'h1;
   end

   // Operation and cycle state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         op <= OP_NONE;
         state <= ST_FIRST;
      end
      else
      begin
         op <= next_op;
         state <= next_state;
      end
   end

   // Instruction fields latched at decode
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         literal <= 8'h00;
         fileAddr <= 8'h00;
         accessBit <= 1'b0;
         dstAddr <= 12'h000;
      end
      else if (takeFirst)
      begin
         literal <= instrWord[7:0];
         fileAddr <= instrWord[7:0];
         accessBit <= instrWord[ACCESS_BIT_POS];
      end
      else if (takeSecond)
         dstAddr <= instrWord[11:0];
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // source read during Q2
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         memRdEn <= 1'b0;
         memRdAddr <= 12'h000;
      end
      else
      begin
         memRdEn <= takeFirst && isMove;
         if (takeFirst && isMove)
            memRdAddr <= instrWord[11:0];
      end
   end

   // operand captured at end of Q2
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         moveData <= 8'h00;
      else if (inQ2 && (op == OP_STORE))
         moveData <= accumulator;
      else if (inQ2 && memRdEn)
         moveData <= readValue;
   end

   // ----------------------------------------------------------------
   // Write path
   // ----------------------------------------------------------------
   // write strobe in Q4
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         memWrEn <= 1'b0;
         wrAccDue <= 1'b0;
         badDest <= 1'b0;
         memWrAddr <= 12'h000;
         memWrData <= 8'h00;
      end
      else
      begin
         memWrEn <= inQ3 && wrDue && !wrIsAcc;
         wrAccDue <= inQ3 && wrDue && wrIsAcc;
         badDest <= inQ3 && (op == OP_MOVE) && (state == ST_SECOND) && dstProtected;
         if (inQ3 && wrDue)
         begin
            memWrAddr <= wrAddr;
            memWrData <= moveData;
         end
      end
   end

   // accumulator updates at end of Q4
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         accumulator <= ACC_RESET;
      else if (inQ4 && (op == OP_ACCLIT))
         accumulator <= literal;
      else if (wrAccDue)
         accumulator <= memWrData;
   end

   // bank select load, upper nibble cleared
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         bankSelect <= BANK_RESET;
      else if (inQ4 && (op == OP_BANK))
         bankSelect <= literal & BANK_MASK;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   src_read_a: assert property (
      takeFirst && isMove |=> memRdEn && inQ2 && (memRdAddr == $past(instrWord[11:0])))
      else $error("source read address wrong");

   dst_write_a: assert property (
      memWrEn && (op == OP_MOVE) |-> (memWrAddr == dstAddr) && (state == ST_SECOND))
      else $error("move destination address wrong");

   acc_dest_a: assert property (
      wrAccDue |=> accumulator == $past(memWrData))
      else $error("accumulator not written by move");

   move_timing_a: assert property (
      (takeFirst && isMove) ##4 takeSecond |-> ##3 inQ4 &&
      (dstProtected ? (badDest && !memWrEn) : ((memWrEn || wrAccDue) && (memWrData == moveData))))
      else $error("move write not in second cycle Q4");

   bank_load_a: assert property (
      takeFirst && isBankLit |-> ##4 bankSelect[3:0] == $past(instrWord[3:0], 4))
      else $error("bank select not loaded");

   bank_upper_a: assert property (
      bankSelect[7:4] == 4'h0)
      else $error("bank select upper bits set");

   acc_load_a: assert property (
      takeFirst && isAccLit |-> ##4 accumulator == $past(instrWord[7:0], 4))
      else $error("accumulator literal not loaded");

   store_data_a: assert property (
      takeFirst && isStore |-> ##3 (memWrEn || wrAccDue) && (memWrData == $past(accumulator, 3)))
      else $error("store data wrong");

   store_bank_a: assert property (
      takeFirst && isStore && instrWord[ACCESS_BIT_POS] |-> ##3
      memWrAddr == {bankSelect[3:0], $past(instrWord[7:0], 3)})
      else $error("banked store address wrong");

   store_access_a: assert property (
      takeFirst && isStore && !instrWord[ACCESS_BIT_POS] && !extEnable |-> ##3
      memWrAddr[7:0] == $past(instrWord[7:0], 3))
      else $error("access bank store address wrong");

   store_index_a: assert property (
      takeFirst && isStore && !instrWord[ACCESS_BIT_POS] && extEnable &&
      (instrWord[7:0] <= INDEX_LIMIT) |-> ##3
      memWrAddr == $past(indexBase, 3) + {4'h0, $past(instrWord[7:0], 3)})
      else $error("indexed store address wrong");

   phase_order_a: assert property (
      (memWrEn |-> inQ4) and (memRdEn |-> inQ2) and (inQ4 |=> inQ1))
      else $error("phase order broken");

   // Main scenarios
   move_done_c: cover property ((op == OP_MOVE) && opDone && (state == ST_SECOND));
   store_index_c: cover property (inQ4 && (op == OP_STORE) && storeIndexed);
   bank_load_c: cover property (inQ4 && (op == OP_BANK));
   acc_move_c: cover property (wrAccDue && (op == OP_MOVE));

endmodule // dmx_move_exec

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench
   import dmx_pkg::*;
();

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk;
   logic rst;
   logic [15:0] instrWord;
   logic instrValid;
   logic instrTaken;
   logic extEnable;
   logic [11:0] indexBase;
   logic memRdEn;
   logic [11:0] memRdAddr;
   logic [7:0] memRdData;
   logic memWrEn;
   logic [11:0] memWrAddr;
   logic [7:0] memWrData;
   logic [7:0] accumulator;
   logic [7:0] bankSelect;
   logic opDone;
   logic badDest;
   int failCount;
   int nTests;
   logic q2Rd;
   logic [11:0] q2Addr;

   dmx_move_exec u_dut (
      .clk(clk), .rst(rst), .instrWord(instrWord), .instrValid(instrValid),
      .instrTaken(instrTaken), .extEnable(extEnable), .indexBase(indexBase),
      .memRdEn(memRdEn), .memRdAddr(memRdAddr), .memRdData(memRdData),
      .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
      .accumulator(accumulator), .bankSelect(bankSelect), .opDone(opDone),
      .badDest(badDest)
   );

   // Memory read: address pattern while enabled, inverted pattern otherwise
   assign memRdData = memRdEn ? (memRdAddr[7:0] ^ 8'h5A) : ~(memRdAddr[7:0] ^ 8'h5A);

   // Clock generator
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [11:0] seen, input logic [11:0] expv);
      nTests++;
      if (seen !== expv)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, seen, expv);
         failCount++;
      end
   endtask

   task automatic conclude;
      if (failCount == 0 && nTests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Offer one word in Q1, return settled in Q4
   task automatic op(input logic [15:0] w);
      instrWord = w;
      instrValid = 1'b1;
      #1;
      chk(instrTaken, 1'b1);
      @(negedge clk);
      instrValid = 1'b0;
      instrWord = ~w;
      #1;
      q2Rd = memRdEn;
      q2Addr = memRdAddr;
      @(negedge clk);
      @(negedge clk);
      #1;
   endtask

   // Step to the next Q1
   task automatic nxt;
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_literals;
      op(16'h0EA5);
      chk(opDone, 1'b1);
      chk(memWrEn, 1'b0);
      nxt;
      chk(accumulator, 8'hA5);
      op(16'h01FF);
      nxt;
      chk(bankSelect, 8'h0F);
      op(16'h0152);
      nxt;
      chk(bankSelect, 8'h02);
   endtask

   task automatic t_store;
      logic [11:0] tbl [7];
      logic [11:0] expA [7];
      op(16'h0E3C);
      nxt;
      // Access bit, ext enable, file address and expected target
      tbl = '{12'h2FF, 12'h200, 12'h05F, 12'h060, 12'h45F, 12'h460, 12'h610};
      expA = '{12'h2FF, 12'h200, 12'h05F, 12'hF60, 12'h84F, 12'hF60, 12'h210};
      for (int i = 0; i < 7; i++)
      begin
         extEnable = tbl[i][10];
         op({7'h37, tbl[i][9], tbl[i][7:0]});
         chk(q2Rd, 1'b0);
         chk(memWrEn, 1'b1);
         chk(memWrAddr, expA[i]);
         chk(memWrData, 8'h3C);
         nxt;
      end
      extEnable = 1'b0;
   endtask

   task automatic t_move(input logic [11:0] src, input logic [11:0] dst,
                         input logic [7:0] dat, input logic wr, input logic bad);
      op({OPC_MOVE_SRC, src});
      chk(q2Rd, 1'b1);
      chk(q2Addr, src);
      chk(memWrEn, 1'b0);
      chk(opDone, 1'b0);
      nxt;
      op({OPC_MOVE_DST, dst});
      chk(q2Rd, 1'b0);
      chk(memWrEn, wr);
      chk(badDest, bad);
      chk(opDone, 1'b1);
      if (wr)
      begin
         chk(memWrAddr, dst);
         chk(memWrData, dat);
      end
      nxt;
   endtask

   task automatic t_moves;
      logic [11:0] prot [4];
      prot = '{PC_LOW_ADDR, STACK_UPPER_ADDR, STACK_HIGH_ADDR, STACK_LOW_ADDR};
      t_move(12'h000, 12'hFFF, 8'h5A, 1'b1, 1'b0);
      t_move(12'hFFF, 12'h000, 8'hA5, 1'b1, 1'b0);
      t_move(ACC_ADDR, 12'h123, 8'h3C, 1'b1, 1'b0);
      t_move(12'h456, ACC_ADDR, 8'h00, 1'b0, 1'b0);
      chk(accumulator, 8'h0C);
      for (int i = 0; i < 4; i++)
         t_move(12'h321, prot[i], 8'h00, 1'b0, 1'b1);
   endtask

   task automatic t_abort;
      op({OPC_MOVE_SRC, 12'h010});
      nxt;
      op(16'h0E77);
      chk(memWrEn, 1'b0);
      chk(opDone, 1'b0);
      nxt;
      chk(accumulator, 8'h0C);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      failCount = 0;
      nTests = 0;
      rst = 1'b1;
      instrWord = 16'h0000;
      instrValid = 1'b0;
      extEnable = 1'b0;
      indexBase = 12'h7F0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      chk(accumulator, ACC_RESET);
      chk(bankSelect, BANK_RESET);
      t_literals;
      t_store;
      t_moves;
      t_abort;
      conclude;
   end

   // Hang guard
   initial
   begin
      repeat (3000) @(posedge clk);
      failCount++;
      conclude;
   end

endmodule // testbench

`default_nettype wire
